// File: rtl/tsp_pipeline.sv
// Purpose: three barrel-pipelined stack processors sharing one memory path
// Assumes: a command is offered for the processor shown on cur_cpu
// Notes: commands start in the processor's next slot; reads sample mem_rdata in-cycle
module tsp_pipeline (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic cmd_valid,
  input wire tsp_pkg::tsp_op_e cmd_op,
  input wire tsp_pkg::tsp_sel_e cmd_sel,
  input wire logic [15:0] cmd_arg,
  output logic cmd_ready,
  output logic [1:0] cur_cpu,
  output logic done,
  output logic [1:0] done_cpu,
  output logic done_ok,
  output logic [7:0] pop_data,
  input wire logic [1:0] rd_cpu,
  input wire tsp_pkg::tsp_sel_e rd_sel,
  output logic [15:0] rd_data,
  output logic mem_en,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  output logic [15:0] ext_addr,
  output logic [7:0] ext_data_o,
  output logic ext_data_oe,
  output logic ext_rw_n
);
  tsp_pkg::tsp_state_s s;
  tsp_pkg::tsp_state_s n;
  tsp_pkg::tsp_cpu_s c;
  tsp_pkg::tsp_cpu_s r;
  logic [1:0] a;
  logic sem_req;
  logic sem_grant;

  assign a = tsp_pkg::slot_idx(s.slot); // RL17
  assign cur_cpu = a;
  assign cmd_ready = !s.half && !s.cpu[a].busy;
  assign sem_req = s.half && s.live && (s.cpu[a].op == tsp_pkg::OP_SEM_ACQ || s.cpu[a].op == tsp_pkg::OP_SEM_REL);
  assign done = s.done;
  assign done_cpu = s.done_cpu;
  assign done_ok = s.done_ok;
  assign pop_data = s.pop_data;
  assign rd_data = s.rd_data;
  assign mem_en = s.mem_en;
  assign mem_we = s.mem_we;
  assign mem_addr = s.mem_addr;
  assign mem_wdata = s.mem_wdata;
  // pins follow the shared path whichever processor owns the phase
  assign ext_addr = s.mem_addr; // RL4
  assign ext_data_o = s.mem_wdata; // RL4
  assign ext_data_oe = s.mem_en && s.mem_we; // RL4
  assign ext_rw_n = !(s.mem_en && s.mem_we); // RL4

  tsp_sem u_sem (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .req_en(sem_req),
    .req_acq(s.cpu[a].op == tsp_pkg::OP_SEM_ACQ),
    .req_idx(s.cpu[a].arg[1:0]),
    .req_cpu(a),
    .grant(sem_grant),
    .owner()
  );

  always_comb begin
    n = s;
    c = s.cpu[a]; // RL3
    r = '0;
    n.done = 1'b0;
    n.mem_en = 1'b0;
    n.mem_we = 1'b0;
    n.half = ~s.half; // RL1
    if (s.half) begin
      n.slot = tsp_pkg::next_slot(s.slot); // RL2 RL16 RL17
    end
    if (!s.half) begin
      n.live = 1'b0;
      if (cmd_valid && cmd_ready) begin
        c.busy = 1'b1;
        c.op = cmd_op;
        c.sel = cmd_sel;
        c.arg = cmd_arg;
        c.step = 1'b0;
      end else if (c.busy) begin
        n.live = 1'b1;
        case (c.op)
          tsp_pkg::OP_PUSH: begin
            n.mem_en = 1'b1;
            n.mem_we = 1'b1;
            n.mem_addr = {c.base_page_sel, c.data_stack_ptr + tsp_pkg::ONE8}; // RL8 RL9 RL10
            n.mem_wdata = c.stack_top; // RL10
          end
          tsp_pkg::OP_POP: begin
            n.mem_en = 1'b1;
            n.mem_addr = {c.base_page_sel, c.data_stack_ptr}; // RL7 RL9 RL11
          end
          tsp_pkg::OP_CALL: begin
            n.mem_en = 1'b1;
            n.mem_we = 1'b1;
            n.mem_addr = {c.base_page_sel, c.return_stack_ptr}; // RL12 RL13
            n.mem_wdata = c.step ? c.instr_pointer[7:0] : c.instr_pointer[15:8]; // RL13
          end
          tsp_pkg::OP_RET: begin
            n.mem_en = 1'b1;
            n.mem_addr = {c.base_page_sel, c.return_stack_ptr + tsp_pkg::ONE8}; // RL14
          end
          default: begin
          end
        endcase
      end
    end else if (s.live) begin
      n.live = 1'b0;
      n.done_cpu = a;
      n.done_ok = 1'b1;
      case (c.op)
        tsp_pkg::OP_PUSH: begin
          c.data_stack_ptr = c.data_stack_ptr + tsp_pkg::ONE8; // RL10
          c.stack_top = c.arg[7:0]; // RL10
          c.busy = 1'b0;
        end
        tsp_pkg::OP_POP: begin
          n.pop_data = c.stack_top; // RL11
          c.stack_top = mem_rdata; // RL11
          c.data_stack_ptr = c.data_stack_ptr - tsp_pkg::ONE8; // RL11
          c.busy = 1'b0;
        end
        tsp_pkg::OP_CALL: begin
          c.return_stack_ptr = c.return_stack_ptr - tsp_pkg::ONE8; // RL12 RL13
          if (c.step) begin
            c.instr_pointer = c.arg; // RL13
            c.busy = 1'b0;
          end
          c.step = 1'b1;
        end
        tsp_pkg::OP_RET: begin
          c.return_stack_ptr = c.return_stack_ptr + tsp_pkg::ONE8; // RL14
          if (c.step) begin
            c.instr_pointer[15:8] = mem_rdata; // RL14
            c.busy = 1'b0;
          end else begin
            c.instr_pointer[7:0] = mem_rdata; // RL14
          end
          c.step = 1'b1;
        end
        tsp_pkg::OP_WREG: begin
          case (c.sel)
            tsp_pkg::SEL_STATUS: begin
              c.status_byte[tsp_pkg::ST_FIO_BIT] = c.arg[tsp_pkg::ST_FIO_BIT]; // RL6
              c.status_byte[tsp_pkg::ST_CARRY_BIT] = c.arg[tsp_pkg::ST_CARRY_BIT]; // RL6
            end
            tsp_pkg::SEL_INSTR: c.instr_pointer = c.arg; // RL5
            tsp_pkg::SEL_PAGE: c.base_page_sel = c.arg[7:0]; // RL8
            tsp_pkg::SEL_DPTR: c.data_stack_ptr = c.arg[7:0];
            tsp_pkg::SEL_RPTR: c.return_stack_ptr = c.arg[7:0];
            tsp_pkg::SEL_TOP: c.stack_top = c.arg[7:0];
            default: n.done_ok = 1'b0;
          endcase
          c.busy = 1'b0;
        end
        tsp_pkg::OP_SEM_ACQ, tsp_pkg::OP_SEM_REL: begin
          n.done_ok = sem_grant; // RL15
          c.busy = 1'b0;
        end
        default: c.busy = 1'b0;
      endcase
      n.done = !c.busy;
    end
    n.cpu[a] = c;
    // the processor number is wired in so software can never forge it
    n.cpu[a].status_byte[tsp_pkg::ST_CPU_LSB +: 2] = a; // RL6
    n.rd_data = 16'h0000;
    if (rd_cpu != 2'h3) begin
      r = s.cpu[rd_cpu];
      if (rd_sel == tsp_pkg::SEL_STATUS) begin
        n.rd_data = {8'h00, r.status_byte};
      end else if (rd_sel == tsp_pkg::SEL_INSTR) begin
        n.rd_data = r.instr_pointer;
      end else if (rd_sel == tsp_pkg::SEL_PAGE) begin
        n.rd_data = {8'h00, r.base_page_sel};
      end else if (rd_sel == tsp_pkg::SEL_DPTR) begin
        n.rd_data = {8'h00, r.data_stack_ptr};
      end else if (rd_sel == tsp_pkg::SEL_RPTR) begin
        n.rd_data = {8'h00, r.return_stack_ptr};
      end else if (rd_sel == tsp_pkg::SEL_TOP) begin
        n.rd_data = {8'h00, r.stack_top};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s <= '0;
      for (int i = 0; i < tsp_pkg::NUM_CPU; i++) begin
        s.cpu[i].instr_pointer <= tsp_pkg::INSTR_RST;
        s.cpu[i].base_page_sel <= tsp_pkg::PAGE_RST;
        s.cpu[i].data_stack_ptr <= tsp_pkg::DPTR_RST;
        s.cpu[i].return_stack_ptr <= tsp_pkg::RPTR_RST;
        // number is valid from reset, not only after the first visit of the slot
        s.cpu[i].status_byte[tsp_pkg::ST_CPU_LSB +: 2] <= 2'(i); // RL6
      end
    end else begin
      s <= n;
    end
  end

  // helper views of the active processor for the checks below
  logic [7:0] h_dptr;
  logic [7:0] h_top;
  logic [7:0] h_instr_hi;
  logic h_take;
  assign h_dptr = s.cpu[a].data_stack_ptr;
  assign h_top = s.cpu[a].stack_top;
  assign h_instr_hi = s.cpu[a].instr_pointer[15:8];
  assign h_take = cmd_valid && cmd_ready;

  property p_phase_len;
    @(posedge sys_clk) disable iff (!rst_b)
    $changed(cur_cpu) |=> $stable(cur_cpu) ##1 $changed(cur_cpu);
  endproperty
  a_phase_len: assert property (p_phase_len) else $error("phase not two clocks"); // RL1

  property p_rotation;
    @(posedge sys_clk) disable iff (!rst_b)
    (cur_cpu == 2'h0) && $changed(cur_cpu) |-> ##2 cur_cpu == 2'h1 ##2 cur_cpu == 2'h2 ##2 cur_cpu == 2'h0;
  endproperty
  a_rotation: assert property (p_rotation) else $error("slot order broken"); // RL17 RL16

  property p_one_access;
    @(posedge sys_clk) disable iff (!rst_b)
    mem_en |=> !mem_en;
  endproperty
  a_one_access: assert property (p_one_access) else $error("two accesses in one phase"); // RL2

  property p_ext_mirror;
    @(posedge sys_clk) disable iff (!rst_b)
    mem_en |-> ext_addr == mem_addr && ext_rw_n == !mem_we && ext_data_oe == mem_we;
  endproperty
  a_ext_mirror: assert property (p_ext_mirror) else $error("external pins disagree"); // RL4

  property p_push;
    @(posedge sys_clk) disable iff (!rst_b)
    h_take && cmd_op == tsp_pkg::OP_PUSH |-> ##7 mem_en && mem_we && mem_addr[7:0] == $past(h_dptr, 7) + 8'h01
      && mem_wdata == $past(h_top, 7) ##1 done;
  endproperty
  a_push: assert property (p_push) else $error("push access wrong"); // RL10

  property p_pop;
    @(posedge sys_clk) disable iff (!rst_b)
    h_take && cmd_op == tsp_pkg::OP_POP |-> ##7 mem_en && !mem_we && mem_addr[7:0] == $past(h_dptr, 7)
      ##1 done && pop_data == $past(h_top, 8);
  endproperty
  a_pop: assert property (p_pop) else $error("pop access wrong"); // RL11

  property p_call;
    @(posedge sys_clk) disable iff (!rst_b)
    h_take && cmd_op == tsp_pkg::OP_CALL |-> ##7 mem_en && mem_we && mem_wdata == $past(h_instr_hi, 7)
      ##6 mem_en && mem_we && mem_addr[7:0] == $past(mem_addr[7:0], 6) - 8'h01 ##1 done;
  endproperty
  a_call: assert property (p_call) else $error("call sequence wrong"); // RL13

  property p_ret;
    @(posedge sys_clk) disable iff (!rst_b)
    h_take && cmd_op == tsp_pkg::OP_RET |-> ##7 mem_en && !mem_we
      ##6 mem_en && !mem_we && mem_addr[7:0] == $past(mem_addr[7:0], 6) + 8'h01 ##1 done;
  endproperty
  a_ret: assert property (p_ret) else $error("return sequence wrong"); // RL14

  property p_cpu_num;
    @(posedge sys_clk) disable iff (!rst_b)
    rd_sel == tsp_pkg::SEL_STATUS && rd_cpu != 2'h3 && $rose(s.half) |=> rd_data[1:0] == $past(rd_cpu);
  endproperty
  a_cpu_num: assert property (p_cpu_num) else $error("status lacks processor number"); // RL6

  c_push: cover property (@(posedge sys_clk) disable iff (!rst_b) h_take && cmd_op == tsp_pkg::OP_PUSH ##8 done);
  c_call: cover property (@(posedge sys_clk) disable iff (!rst_b) h_take && cmd_op == tsp_pkg::OP_CALL ##14 done);
  c_ret: cover property (@(posedge sys_clk) disable iff (!rst_b) h_take && cmd_op == tsp_pkg::OP_RET ##14 done);
  c_sem: cover property (@(posedge sys_clk) disable iff (!rst_b) done && !done_ok);
endmodule : tsp_pipeline

// File: rtl/tsp_pkg.sv
// Purpose: constants and types of the triple stack processor pipeline
// Assumes: sys_clk is the input clock; the system clock phase is two of its periods
// Notes: memory reads are combinational within the access cycle
// Behaviour
// RL1: a minor cycle is three system phases, each phase two input clocks
// RL2: processor slots are staggered one phase; one memory and ALU use each
// RL3: each of three processors has private registers; access path is shared
// RL4: internal address, data and read/write-not are mirrored on external pins
// RL5: instruction pointer is 16 bits; other processor registers 8 bits
// RL6: status byte holds processor number, fast I/O select and carry
// RL7: 8-bit data stack; ALU operands are stack top and second entry in RAM
// RL8: each processor has a private 256-byte base page chosen by its select
// RL9: second data entry sits at base page plus data pointer, growing upward
// RL10: push increments pointer, stores old top there, loads new top
// RL11: pop emits top, reloads top from base page plus pointer, decrements
// RL12: return stack lives in the base page and grows downward
// RL13: call stores high then low pointer byte, decrementing, then jumps
// RL14: return increments, loads low byte, increments, loads high byte
// RL15: hardware semaphores arbitrate ownership of shared buffers
// RL16: an instruction cycle is three phases, six input clocks
// RL17: active register set rotates one, two, three, one per phase
package tsp_pkg;
  localparam int T_CLK_NS = 50;
  localparam int PHASE_CLKS = 2;
  localparam int MINOR_PHASES = 3;
  localparam int INSTR_CLKS = PHASE_CLKS * MINOR_PHASES;
  localparam int NUM_SEM = 4;
  localparam int NUM_CPU = 3;
  localparam logic [7:0] ONE8 = 8'h01;
  localparam logic [7:0] DPTR_RST = 8'h00;
  localparam logic [7:0] RPTR_RST = 8'hFF;
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam int ST_CPU_LSB = 0;
  localparam int ST_FIO_BIT = 2;
  localparam int ST_CARRY_BIT = 3;
  localparam logic [1:0] SEM_FREE = 2'h0;

  typedef enum logic [1:0] {
    SLOT_P1 = 2'h0,
    SLOT_P2 = 2'h1,
    SLOT_P3 = 2'h3
  } tsp_slot_e;

  typedef enum logic [2:0] {
    OP_NOP = 3'h0,
    OP_PUSH = 3'h1,
    OP_POP = 3'h2,
    OP_CALL = 3'h3,
    OP_RET = 3'h4,
    OP_WREG = 3'h5,
    OP_SEM_ACQ = 3'h6,
    OP_SEM_REL = 3'h7
  } tsp_op_e;

  typedef enum logic [2:0] {
    SEL_STATUS = 3'h0,
    SEL_INSTR = 3'h1,
    SEL_PAGE = 3'h2,
    SEL_DPTR = 3'h3,
    SEL_RPTR = 3'h4,
    SEL_TOP = 3'h5
  } tsp_sel_e;

  typedef struct packed {
    logic [15:0] instr_pointer;
    logic [7:0] status_byte;
    logic [7:0] base_page_sel;
    logic [7:0] data_stack_ptr;
    logic [7:0] return_stack_ptr;
    logic [7:0] stack_top;
    tsp_op_e op;
    tsp_sel_e sel;
    logic [15:0] arg;
    logic step;
    logic busy;
  } tsp_cpu_s;

  typedef struct packed {
    logic half;
    tsp_slot_e slot;
    logic live;
    tsp_cpu_s [2:0] cpu;
    logic mem_en;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [7:0] mem_wdata;
    logic done;
    logic [1:0] done_cpu;
    logic done_ok;
    logic [7:0] pop_data;
    logic [15:0] rd_data;
  } tsp_state_s;

  typedef struct packed {
    logic [NUM_SEM-1:0][1:0] owner;
  } tsp_sem_s;

  function automatic logic [1:0] slot_idx(input tsp_slot_e s);
    case (s)
      SLOT_P1: slot_idx = 2'h0;
      SLOT_P2: slot_idx = 2'h1;
      default: slot_idx = 2'h2;
    endcase
  endfunction : slot_idx

  function automatic tsp_slot_e next_slot(input tsp_slot_e s);
    case (s)
      SLOT_P1: next_slot = SLOT_P2;
      SLOT_P2: next_slot = SLOT_P3;
      default: next_slot = SLOT_P1;
    endcase
  endfunction : next_slot
endpackage : tsp_pkg

// File: rtl/tsp_sem.sv
// Purpose: bank of hardware semaphores shared by the three processors
// Assumes: at most one request per cycle, as the slots serialise the processors
// Notes: owner code is processor number plus one; zero means free
module tsp_sem (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic req_en,
  input wire logic req_acq,
  input wire logic [1:0] req_idx,
  input wire logic [1:0] req_cpu,
  output logic grant,
  output logic [tsp_pkg::NUM_SEM-1:0][1:0] owner
);
  tsp_pkg::tsp_sem_s s;
  tsp_pkg::tsp_sem_s n;
  logic [1:0] code;

  assign code = req_cpu + 2'h1;
  assign owner = s.owner;
  // re-acquire by the owner succeeds so a retry loop never deadlocks itself
  assign grant = req_acq ? (s.owner[req_idx] == tsp_pkg::SEM_FREE || s.owner[req_idx] == code)
                         : (s.owner[req_idx] == code); // RL15

  always_comb begin
    n = s;
    for (int i = 0; i < tsp_pkg::NUM_SEM; i++) begin
      if (req_en && grant && req_idx == i[1:0]) begin
        n.owner[i] = req_acq ? code : tsp_pkg::SEM_FREE; // RL15
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  property p_sem_owner;
    @(posedge sys_clk) disable iff (!rst_b)
    req_en && req_acq && grant |=> owner[$past(req_idx)] == $past(code);
  endproperty
  a_sem_owner: assert property (p_sem_owner) else $error("semaphore not taken by grantee"); // RL15
endmodule : tsp_sem

// File: tb/tsp_mem_model.sv
// Purpose: shared ram seen by the pipeline's memory port
// Assumes: reads answer combinationally while mem_en is high
// Notes: outside a read the data bus shows the inverse of the last byte, so a stale sample cannot pass
module tsp_mem_model (
  input wire logic sys_clk,
  input wire logic mem_en,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] ram [0:65535];
  logic [7:0] last_r = 8'h00;
  always_ff @(posedge sys_clk) begin
    if (mem_en && mem_we) begin
      ram[mem_addr] <= mem_wdata;
    end
    if (mem_en && !mem_we) begin
      last_r <= ram[mem_addr];
    end
  end
  always_comb begin
    mem_rdata = (mem_en && !mem_we) ? ram[mem_addr] : ~last_r;
  end
endmodule : tsp_mem_model

// File: tb/tsp_pipeline_tb.sv
// Purpose: self-checking bench for the triple stack processor pipeline
// Assumes: results return in the order commands were taken
// Notes: slots are found from cur_cpu; one rotation is six clocks
module tsp_pipeline_tb;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {logic [1:0] c; logic ok; logic hp; logic [7:0] pd; int at;} tsp_note_s;
  logic sys_clk, rst_b, cmd_valid, cmd_ready, done, done_ok, mem_en, mem_we, ext_data_oe, ext_rw_n;
  tsp_pkg::tsp_op_e cmd_op;
  tsp_pkg::tsp_sel_e cmd_sel, rd_sel;
  logic [15:0] cmd_arg, rd_data, mem_addr, ext_addr;
  logic [1:0] cur_cpu, done_cpu, rd_cpu, prev;
  logic [7:0] pop_data, mem_wdata, mem_rdata, ext_data_o;
  logic [7:0] e_top [3], e_dpt [3], e_rpt [3], e_pg [3];
  logic [15:0] e_ipt [3];
  logic [7:0] shadow [logic [15:0]];
  logic [5:0] sem_tab [8] = '{6'h0B, 6'h1A, 6'h12, 6'h03, 6'h1B, 6'h2F, 6'h13, 6'h27};
  tsp_note_s q[$];
  tsp_note_s n;
  int cyc, n_mismatch, compares;
  logic [31:0] rs;

  tsp_pipeline tsp_pipeline_inst (.sys_clk(sys_clk), .rst_b(rst_b), .cmd_valid(cmd_valid), .cmd_op(cmd_op),
    .cmd_sel(cmd_sel), .cmd_arg(cmd_arg), .cmd_ready(cmd_ready), .cur_cpu(cur_cpu), .done(done),
    .done_cpu(done_cpu), .done_ok(done_ok), .pop_data(pop_data), .rd_cpu(rd_cpu), .rd_sel(rd_sel),
    .rd_data(rd_data), .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata), .ext_addr(ext_addr), .ext_data_o(ext_data_o), .ext_data_oe(ext_data_oe),
    .ext_rw_n(ext_rw_n));
  tsp_mem_model tsp_mem_model_inst (.sys_clk(sys_clk), .mem_en(mem_en), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) cyc <= cyc + 1;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic conclude();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : conclude

  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    xs = y ^ (y << 5);
  endfunction : xs

  // monitor: each done takes the oldest note; every access is mirrored on the pins
  always @(negedge sys_clk) begin
    prev <= cur_cpu;
    if (rst_b === 1'b1 && done === 1'b1) begin
      if (q.size() == 0) begin
        check("spare done", 16'h1, 16'h0);
      end else begin
        n = q.pop_front();
        check("done time", 16'(cyc), 16'(n.at));
        check("done cpu", {14'h0, done_cpu}, {14'h0, n.c});
        check("done ok", {15'h0, done_ok}, {15'h0, n.ok});
        if (n.hp) check("pop data", {8'h00, pop_data}, {8'h00, n.pd});
      end
    end
    if (mem_en === 1'b1) begin
      check("ext addr", ext_addr, mem_addr);
      check("ext rw", {14'h0, ext_rw_n, ext_data_oe}, {14'h0, ~mem_we, mem_we});
      if (mem_we === 1'b1) check("ext data", {8'h00, ext_data_o}, {8'h00, mem_wdata});
    end
  end

  task automatic wait_idle();
    for (int k = 0; k < 100 && q.size() > 0; k++) @(posedge sys_clk);
    if (q.size() > 0) begin
      check("idle wait", 16'h1, 16'h0);
      conclude();
    end
    @(posedge sys_clk);
  endtask : wait_idle

  // waits for the cpu's half-0 cycle, then offers the command one rotation later
  task automatic issue(input logic [1:0] c, input tsp_pkg::tsp_op_e op, input tsp_pkg::tsp_sel_e sel,
                       input logic [15:0] arg, input logic ok, input logic hp, input logic [7:0] pd);
    tsp_note_s m;
    logic sent;
    sent = 1'b0;
    for (int t = 0; t < 40 && !sent; t++) begin
      @(negedge sys_clk);
      if (cur_cpu === c && prev !== c) begin
        repeat (6) @(posedge sys_clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_sel <= sel;
        cmd_arg <= arg;
        @(negedge sys_clk);
        check("slot order", {14'h0, cur_cpu}, {14'h0, c});
        if (cmd_ready === 1'b1) begin
          m = '{c, ok, hp, pd, cyc + ((op == tsp_pkg::OP_CALL || op == tsp_pkg::OP_RET) ? 14 : 8)};
          q.push_back(m);
          sent = 1'b1;
        end
        @(posedge sys_clk);
        cmd_valid <= 1'b0;
        @(negedge sys_clk);
        check("ready in half one", {15'h0, cmd_ready}, 16'h0000);
      end
    end
    if (!sent) begin
      check("command taken", 16'h0, 16'h1);
      conclude();
    end
  endtask : issue

  task automatic rd(input logic [1:0] c, input tsp_pkg::tsp_sel_e s, input logic [15:0] exp, input string what);
    @(posedge sys_clk);
    rd_cpu <= c;
    rd_sel <= s;
    @(posedge sys_clk);
    @(negedge sys_clk);
    check(what, rd_data, exp);
  endtask : rd

  task automatic verify(input logic [1:0] c);
    rd(c, tsp_pkg::SEL_TOP, {8'h00, e_top[c]}, "stack top");
    rd(c, tsp_pkg::SEL_DPTR, {8'h00, e_dpt[c]}, "data pointer");
    rd(c, tsp_pkg::SEL_RPTR, {8'h00, e_rpt[c]}, "return pointer");
    rd(c, tsp_pkg::SEL_PAGE, {8'h00, e_pg[c]}, "base page");
    rd(c, tsp_pkg::SEL_INSTR, e_ipt[c], "instr pointer");
  endtask : verify

  task automatic wreg(input logic [1:0] c, input tsp_pkg::tsp_sel_e s, input logic [15:0] v);
    issue(c, tsp_pkg::OP_WREG, s, v, 1'b1, 1'b0, 8'h00);
    if (s == tsp_pkg::SEL_INSTR) e_ipt[c] = v;
    if (s == tsp_pkg::SEL_PAGE) e_pg[c] = v[7:0];
    if (s == tsp_pkg::SEL_DPTR) e_dpt[c] = v[7:0];
    if (s == tsp_pkg::SEL_RPTR) e_rpt[c] = v[7:0];
    if (s == tsp_pkg::SEL_TOP) e_top[c] = v[7:0];
    wait_idle();
  endtask : wreg

  task automatic push(input logic [1:0] c, input logic [7:0] b);
    logic [15:0] a;
    issue(c, tsp_pkg::OP_PUSH, tsp_pkg::SEL_STATUS, {8'h00, b}, 1'b1, 1'b0, 8'h00);
    e_dpt[c] = e_dpt[c] + 8'h01;
    a = {e_pg[c], e_dpt[c]};
    shadow[a] = e_top[c];
    e_top[c] = b;
    wait_idle();
    check("pushed byte", {8'h00, tsp_mem_model_inst.ram[a]}, {8'h00, shadow[a]});
    verify(c);
  endtask : push

  task automatic pop(input logic [1:0] c);
    issue(c, tsp_pkg::OP_POP, tsp_pkg::SEL_STATUS, 16'h0000, 1'b1, 1'b1, e_top[c]);
    e_top[c] = shadow[{e_pg[c], e_dpt[c]}];
    e_dpt[c] = e_dpt[c] - 8'h01;
    wait_idle();
    verify(c);
  endtask : pop

  task automatic call_ret(input logic [1:0] c, input logic is_call, input logic [15:0] t);
    logic [15:0] a;
    logic [15:0] b;
    a = {e_pg[c], e_rpt[c]};
    b = {e_pg[c], e_rpt[c] - 8'h01};
    if (is_call) begin
      shadow[a] = e_ipt[c][15:8];
      shadow[b] = e_ipt[c][7:0];
      e_rpt[c] = e_rpt[c] - 8'h02;
      issue(c, tsp_pkg::OP_CALL, tsp_pkg::SEL_STATUS, t, 1'b1, 1'b0, 8'h00);
      e_ipt[c] = t;
      wait_idle();
      check("call high", {8'h00, tsp_mem_model_inst.ram[a]}, {8'h00, shadow[a]});
      check("call low", {8'h00, tsp_mem_model_inst.ram[b]}, {8'h00, shadow[b]});
    end else begin
      e_ipt[c] = {shadow[{e_pg[c], e_rpt[c] + 8'h02}], shadow[{e_pg[c], e_rpt[c] + 8'h01}]};
      e_rpt[c] = e_rpt[c] + 8'h02;
      issue(c, tsp_pkg::OP_RET, tsp_pkg::SEL_STATUS, 16'h0000, 1'b1, 1'b0, 8'h00);
      wait_idle();
    end
    verify(c);
  endtask : call_ret

  initial begin
    rst_b = 1'b0;
    cmd_valid = 1'b0;
    cmd_op = tsp_pkg::OP_NOP;
    cmd_sel = tsp_pkg::SEL_STATUS;
    cmd_arg = 16'h0000;
    rd_cpu = 2'h3;
    rd_sel = tsp_pkg::SEL_STATUS;
    cyc = 0;
    n_mismatch = 0;
    compares = 0;
    rs = 32'haed5;
    prev = 2'h0;
    repeat (10) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    check("first slot", {13'h0, cmd_ready, cur_cpu}, 16'h0004);
    for (int c = 0; c < 3; c++) begin
      e_top[c] = 8'h00;
      e_dpt[c] = 8'h00;
      e_rpt[c] = 8'hFF;
      e_pg[c] = 8'h00;
      e_ipt[c] = 16'h0000;
      rd(2'(c), tsp_pkg::SEL_STATUS, 16'(c), "cpu number");
      verify(2'(c));
    end
    $display("test reset values done");
    for (int c = 0; c < 3; c++) begin
      rs = xs(rs);
      wreg(2'(c), tsp_pkg::SEL_PAGE, {8'h00, 2'(c), rs[5:0]});
      wreg(2'(c), tsp_pkg::SEL_INSTR, rs[31:16]);
    end
    wreg(2'h2, tsp_pkg::SEL_STATUS, 16'h000F);
    rd(2'h2, tsp_pkg::SEL_STATUS, 16'h000E, "status bits");
    issue(2'h1, tsp_pkg::OP_WREG, tsp_pkg::tsp_sel_e'(3'h6), 16'h0055, 1'b0, 1'b0, 8'h00);
    wait_idle();
    rs = xs(rs);
    wreg(2'h0, tsp_pkg::SEL_DPTR, {8'h00, rs[7:0]});
    wreg(2'h0, tsp_pkg::SEL_TOP, {8'h00, rs[15:8]});
    wreg(2'h1, tsp_pkg::SEL_RPTR, {8'h00, rs[23:16]});
    issue(2'h2, tsp_pkg::OP_NOP, tsp_pkg::SEL_STATUS, 16'h0000, 1'b1, 1'b0, 8'h00);
    wait_idle();
    for (int c = 0; c < 3; c++) verify(2'(c));
    $display("test register writes done");
    for (int i = 0; i < 3; i++) begin
      rs = xs(rs);
      push(2'h0, rs[7:0]);
      push(2'h2, rs[15:8]);
    end
    for (int i = 0; i < 3; i++) begin
      pop(2'h2);
      pop(2'h0);
    end
    $display("test data stack done");
    rs = xs(rs);
    call_ret(2'h1, 1'b1, rs[15:0]);
    call_ret(2'h1, 1'b1, rs[31:16]);
    call_ret(2'h1, 1'b0, 16'h0000);
    call_ret(2'h1, 1'b0, 16'h0000);
    $display("test call return done");
    for (int i = 0; i < 8; i++) begin
      issue(sem_tab[i][5:4], sem_tab[i][3] ? tsp_pkg::OP_SEM_ACQ : tsp_pkg::OP_SEM_REL, tsp_pkg::SEL_STATUS,
            {14'h0, sem_tab[i][2:1]}, sem_tab[i][0], 1'b0, 8'h00);
      wait_idle();
    end
    $display("test semaphores done");
    conclude();
  end
endmodule : tsp_pipeline_tb
